// File: rtl/ascr_top.sv
// Purpose: Serial configuration register bank; words arrive on the serial clock, banks live on clk.
// Assumes: Frame sync is high for exactly sixteen serial clocks per word; data is sampled on rising edges.
// Notes:   The serial clock must run at least four cycles with frame sync low before a readback frame.
`timescale 1ns/100ps

// Contract
// - Read loads bank for shifting; write stores data.
// - Select 001 holds transmit corner word.
// - Select 010 write loads receive corner word.
// - Control bit 11 low: transmit down, hi-Z.
// - Control bit 10 low: receive powered down.
// - Control bit 9 high: analog loopback.
// - Control bit 8 one: bypass ADC buffer.
// - Control bit 7 one: bypass anti-alias filter.
// - Control bit 6 one: six dB attenuation.
// - Filter bit 11 writes both corner words.
// - Corner words eleven bits, separate registers.
// - Path bits all zero: full transmit chain.
// - Bit 5 only: DAC to line, driver hi-Z.
// - Bit 4 only: skip filter, filter hi-Z.
// - Bit 3 only: filter to line, driver hi-Z.
// - Gain codes map -6 to 9 dB.
// - Corner bits 8 to 10 pick range.
// - Port: clock, frame sync, data in, out.
// - Low master reset resets the device.
module ascr_top
    import ascr_pkg::*;
(
    input  wire logic           clk,
    input  wire logic           rst_n,
    input  wire logic           cfg_serial_clock,
    input  wire logic           cfg_frame_sync,
    input  wire logic           cfg_serial_in,
    output logic                cfg_serial_out,
    output ascr_afe_ctrl_s      afe_ctrl
);

    // Gain code to dB; codes above the top step saturate.
    function automatic logic signed [4:0] gain_db(input logic [2:0] code);
        logic [2:0] c;
        c = (code > GAIN_MAX_CODE) ? GAIN_MAX_CODE : code;
        gain_db = 5'(GAIN_MIN_DB + GAIN_STEP_DB * $signed({2'b00, c}));
    endfunction

    // Link domain state.
    logic [WORD_W-1:0]   in_shift_reg;
    logic [CNT_W-1:0]    bit_cnt_reg;
    logic [WORD_W-1:0]   word_hold_reg;
    logic                word_tgl_reg;
    logic [WORD_W-1:0]   out_shift_reg;
    logic                rd_tgl_s1_reg;
    logic                rd_tgl_s2_reg;
    logic                rd_seen_reg;

    // System domain state.
    logic                word_s1_reg;
    logic                word_s2_reg;
    logic                word_s3_reg;
    logic [DATA_W-1:0]   ctrl_reg;
    logic [CORNER_W-1:0] tx_corner_reg;
    logic [CORNER_W-1:0] rx_corner_reg;
    logic [WORD_W-1:0]   rd_word_reg;
    logic                rd_tgl_reg;

    logic                new_word;
    logic                word_is_read;
    ascr_bank_e          word_bank;
    logic [DATA_W-1:0]   word_data;
    logic [DATA_W-1:0]   bank_data;
    logic                wr_tx;
    logic                wr_rx;

    // Shift in during the frame, MSB first; the word is only released after all sixteen bits.
    always_ff @(posedge cfg_serial_clock or negedge rst_n) begin
        if (!rst_n) begin
            in_shift_reg  <= WORD_RST;
            bit_cnt_reg   <= '0;
            word_hold_reg <= WORD_RST;
            word_tgl_reg  <= 1'b0;
        end else if (cfg_frame_sync) begin
            in_shift_reg <= {in_shift_reg[WORD_W-2:0], cfg_serial_in};
            bit_cnt_reg  <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == LAST_BIT) begin
                word_hold_reg <= {in_shift_reg[WORD_W-2:0], cfg_serial_in};
                word_tgl_reg  <= ~word_tgl_reg;
            end
        end else begin
            bit_cnt_reg <= '0;  // A short frame is dropped, never decoded.
        end
    end

    // Bring the read toggle into the link domain.
    always_ff @(posedge cfg_serial_clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_tgl_s1_reg <= 1'b0;
            rd_tgl_s2_reg <= 1'b0;
        end else begin
            rd_tgl_s1_reg <= rd_tgl_reg;
            rd_tgl_s2_reg <= rd_tgl_s1_reg;
        end
    end

    // Load the readback word between frames, then shift it out during the next frame.
    // Loading only while frame sync is low keeps a word from changing mid-shift.
    always_ff @(posedge cfg_serial_clock or negedge rst_n) begin
        if (!rst_n) begin
            out_shift_reg <= WORD_RST;
            rd_seen_reg   <= 1'b0;
        end else if (cfg_frame_sync) begin
            out_shift_reg <= {out_shift_reg[WORD_W-2:0], 1'b0};
        end else if (rd_tgl_s2_reg != rd_seen_reg) begin
            out_shift_reg <= rd_word_reg;
            rd_seen_reg   <= rd_tgl_s2_reg;
        end
    end

    assign cfg_serial_out = out_shift_reg[WORD_W-1];

    // Word toggle into the system domain; the held word is stable for a whole frame after it.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            word_s1_reg <= 1'b0;
            word_s2_reg <= 1'b0;
            word_s3_reg <= 1'b0;
        end else begin
            word_s1_reg <= word_tgl_reg;
            word_s2_reg <= word_s1_reg;
            word_s3_reg <= word_s2_reg;
        end
    end

    // Field split of the received word and bank readback mux.
    assign new_word     = word_s2_reg ^ word_s3_reg;
    assign word_is_read = word_hold_reg[RW_BIT];
    assign word_bank    = ascr_bank_e'(word_hold_reg[SEL_HI:SEL_LO]);
    assign word_data    = word_hold_reg[DATA_W-1:0];
    assign wr_tx        = new_word && !word_is_read &&
                          (word_bank == BANK_TX || (word_bank == BANK_RX && word_data[DUAL_WR_BIT]));
    assign wr_rx        = new_word && !word_is_read &&
                          (word_bank == BANK_RX || (word_bank == BANK_TX && word_data[DUAL_WR_BIT]));

    // Test bank and undefined selects read as zero.
    always_comb begin
        case (word_bank)
            BANK_CTRL: bank_data = ctrl_reg;
            BANK_TX:   bank_data = {1'b0, tx_corner_reg};
            BANK_RX:   bank_data = {1'b0, rx_corner_reg};
            default:   bank_data = CTRL_RST;
        endcase
    end

    // General control bank writes; the test bank ignores writes.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= CTRL_RST;
        end else if (new_word && !word_is_read && word_bank == BANK_CTRL) begin
            ctrl_reg <= word_data;
        end
    end

    // Separate eleven-bit corner registers; the dual write bit copies one word into both.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_corner_reg <= CORNER_RST;
            rx_corner_reg <= CORNER_RST;
        end else begin
            if (wr_tx) begin
                tx_corner_reg <= word_data[CORNER_W-1:0];
            end
            if (wr_rx) begin
                rx_corner_reg <= word_data[CORNER_W-1:0];
            end
        end
    end

    // Read request: capture the bank, then hand it across by toggle.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_word_reg <= WORD_RST;
            rd_tgl_reg  <= 1'b0;
        end else if (new_word && word_is_read) begin
            rd_word_reg <= {word_hold_reg[RW_BIT:SEL_LO], bank_data};
            rd_tgl_reg  <= ~rd_tgl_reg;
        end
    end

    // Registered decode of the banks onto the analog controls.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            afe_ctrl <= '0;
        end else begin
            afe_ctrl.transmit_power_on_n <= ctrl_reg[CTL_TX_ON];
            afe_ctrl.receive_power_on_n  <= ctrl_reg[CTL_RX_ON];
            afe_ctrl.tx_line_hiz         <= !ctrl_reg[CTL_TX_ON];
            afe_ctrl.loopback            <= ctrl_reg[CTL_LOOP];
            afe_ctrl.adc_buffer_skip     <= ctrl_reg[CTL_ADCBUF];
            afe_ctrl.rx_antialias_skip   <= ctrl_reg[CTL_AAF];
            afe_ctrl.tx_atten_6db        <= ctrl_reg[CTL_ATTEN];
            afe_ctrl.dac_direct_to_line  <= ctrl_reg[CTL_DAC];
            afe_ctrl.tx_filter_skip      <= ctrl_reg[CTL_TXF];
            afe_ctrl.line_driver_skip    <= ctrl_reg[CTL_DRV];
            afe_ctrl.driver_amp_hiz      <= ctrl_reg[CTL_DAC] | ctrl_reg[CTL_DRV];
            afe_ctrl.filter_amp_hiz      <= ctrl_reg[CTL_TXF];
            afe_ctrl.rx_gain_db          <= gain_db(ctrl_reg[GAIN_HI:GAIN_LO]);
            afe_ctrl.tx_corner_word      <= tx_corner_reg;
            afe_ctrl.rx_corner_word      <= rx_corner_reg;
            afe_ctrl.tx_range            <= tx_corner_reg[RANGE_HI:RANGE_LO];
            afe_ctrl.rx_range            <= rx_corner_reg[RANGE_HI:RANGE_LO];
        end
    end

    // Checks in the system domain.
    chk_ctrl_write_store: assert property (@(posedge clk) disable iff (!rst_n)
        (new_word && !word_is_read && word_bank == BANK_CTRL) |=> (ctrl_reg == $past(word_data)))
        else $error("control bank write not stored");

    chk_tx_corner_load: assert property (@(posedge clk) disable iff (!rst_n)
        (new_word && !word_is_read && word_bank == BANK_TX)
        |=> (tx_corner_reg == $past(word_data[CORNER_W-1:0])))
        else $error("transmit corner word not loaded");

    chk_rx_corner_load: assert property (@(posedge clk) disable iff (!rst_n)
        (new_word && !word_is_read && word_bank == BANK_RX)
        |=> (rx_corner_reg == $past(word_data[CORNER_W-1:0])))
        else $error("receive corner word not loaded");

    chk_dual_write_both: assert property (@(posedge clk) disable iff (!rst_n)
        (new_word && !word_is_read && (word_bank == BANK_TX || word_bank == BANK_RX)
         && word_data[DUAL_WR_BIT]) |=> (tx_corner_reg == rx_corner_reg))
        else $error("dual write did not reach both corner registers");

    chk_rx_no_cross: assert property (@(posedge clk) disable iff (!rst_n)
        (new_word && !word_is_read && word_bank == BANK_RX && !word_data[DUAL_WR_BIT])
        |=> $stable(tx_corner_reg))
        else $error("receive-only write changed transmit corner");

    chk_read_no_store: assert property (@(posedge clk) disable iff (!rst_n)
        (new_word && word_is_read) |=> ($stable(ctrl_reg) && $stable(tx_corner_reg) && $stable(rx_corner_reg)
                                        && rd_word_reg[DATA_W-1:0] == $past(bank_data)))
        else $error("read altered a bank or captured wrong data");

    chk_tx_power_hiz: assert property (@(posedge clk) disable iff (!rst_n)
        !ctrl_reg[CTL_TX_ON] |=> (afe_ctrl.tx_line_hiz && !afe_ctrl.transmit_power_on_n))
        else $error("transmit power down not reflected");

    chk_gain_map: assert property (@(posedge clk) disable iff (!rst_n)
        (ctrl_reg[GAIN_HI:GAIN_LO] == 3'h2) |=> (afe_ctrl.rx_gain_db == 5'sd0))
        else $error("receive gain code 2 is not 0 dB");

    chk_gain_saturate: assert property (@(posedge clk) disable iff (!rst_n)
        (ctrl_reg[GAIN_HI] && ctrl_reg[GAIN_HI-1]) |=> (afe_ctrl.rx_gain_db == 5'sd9))
        else $error("receive gain does not saturate at 9 dB");

    chk_driver_hiz: assert property (@(posedge clk) disable iff (!rst_n)
        (ctrl_reg[CTL_DAC] && !ctrl_reg[CTL_TXF] && !ctrl_reg[CTL_DRV])
        |=> (afe_ctrl.driver_amp_hiz && !afe_ctrl.filter_amp_hiz))
        else $error("DAC-to-line path hi-Z states wrong");

    chk_filter_hiz: assert property (@(posedge clk) disable iff (!rst_n)
        (ctrl_reg[CTL_TXF] && !ctrl_reg[CTL_DAC] && !ctrl_reg[CTL_DRV])
        |=> (afe_ctrl.filter_amp_hiz && !afe_ctrl.driver_amp_hiz))
        else $error("filter bypass hi-Z states wrong");

    // Decode checks for the remaining control bits and the corner range; each looks one clk later, but only attenuation and range are checked for every bit value.
    chk_rx_power_down: assert property (@(posedge clk) disable iff (!rst_n)
        !ctrl_reg[CTL_RX_ON]
        |=> !afe_ctrl.receive_power_on_n)
        else $error("receive power down not reflected");

    chk_loopback_select: assert property (@(posedge clk) disable iff (!rst_n)
        ctrl_reg[CTL_LOOP]
        |=> afe_ctrl.loopback)
        else $error("analog loopback not selected");

    chk_adc_buffer_skip: assert property (@(posedge clk) disable iff (!rst_n)
        ctrl_reg[CTL_ADCBUF]
        |=> afe_ctrl.adc_buffer_skip)
        else $error("ADC buffer bypass not selected");

    chk_antialias_skip: assert property (@(posedge clk) disable iff (!rst_n)
        ctrl_reg[CTL_AAF]
        |=> afe_ctrl.rx_antialias_skip)
        else $error("anti-alias filter bypass not selected");

    chk_tx_atten_follow: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1
        |=> (afe_ctrl.tx_atten_6db == $past(ctrl_reg[CTL_ATTEN])))
        else $error("transmit attenuation does not follow its bit");

    chk_full_tx_chain: assert property (@(posedge clk) disable iff (!rst_n)
        (ctrl_reg[CTL_DAC:CTL_DRV] == 3'h0)
        |=> !(afe_ctrl.dac_direct_to_line || afe_ctrl.tx_filter_skip || afe_ctrl.line_driver_skip
              || afe_ctrl.driver_amp_hiz || afe_ctrl.filter_amp_hiz))
        else $error("default transmit chain not in use");

    chk_filter_to_line: assert property (@(posedge clk) disable iff (!rst_n)
        (ctrl_reg[CTL_DRV] && !ctrl_reg[CTL_DAC] && !ctrl_reg[CTL_TXF])
        |=> (afe_ctrl.line_driver_skip && afe_ctrl.driver_amp_hiz && !afe_ctrl.filter_amp_hiz))
        else $error("driver bypass hi-Z states wrong");

    chk_corner_range: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1
        |=> (afe_ctrl.tx_range == $past(tx_corner_reg[RANGE_HI:RANGE_LO])
             && afe_ctrl.rx_range == $past(rx_corner_reg[RANGE_HI:RANGE_LO])))
        else $error("corner range select does not follow the corner words");

    // Bank and handover checks; a bank may only move on a complete, decoded word.
    chk_corner_separate: assert property (@(posedge clk) disable iff (!rst_n)
        (new_word && !word_is_read && word_bank == BANK_TX && !word_data[DUAL_WR_BIT])
        |=> $stable(rx_corner_reg))
        else $error("transmit-only write changed receive corner");

    chk_test_bank_ignored: assert property (@(posedge clk) disable iff (!rst_n)
        (new_word && !word_is_read && word_bank == BANK_TEST)
        |=> ($stable(ctrl_reg) && $stable(tx_corner_reg) && $stable(rx_corner_reg)))
        else $error("write to the factory test bank changed a bank");

    chk_banks_idle_stable: assert property (@(posedge clk) disable iff (!rst_n)
        !new_word
        |=> ($stable(ctrl_reg) && $stable(tx_corner_reg) && $stable(rx_corner_reg)))
        else $error("bank changed without a complete word");

    chk_read_echo: assert property (@(posedge clk) disable iff (!rst_n)
        (new_word && word_is_read)
        |=> (rd_word_reg[WORD_W-1:SEL_LO] == $past(word_hold_reg[RW_BIT:SEL_LO])
             && (rd_tgl_reg != $past(rd_tgl_reg))))
        else $error("readback header not captured or not handed over");

    // Checks in the link domain.
    chk_word_after_16: assert property (@(posedge cfg_serial_clock) disable iff (!rst_n)
        (cfg_frame_sync && bit_cnt_reg != LAST_BIT) |=> $stable(word_tgl_reg))
        else $error("word released before sixteen bits");

    chk_out_shift: assert property (@(posedge cfg_serial_clock) disable iff (!rst_n)
        cfg_frame_sync |=> (out_shift_reg[WORD_W-1] == $past(out_shift_reg[WORD_W-2])))
        else $error("readback word not shifted MSB first");

    chk_short_frame_drop: assert property (@(posedge cfg_serial_clock) disable iff (!rst_n)
        !cfg_frame_sync
        |=> (bit_cnt_reg == '0))
        else $error("bit counter not cleared between frames");

    chk_load_idle_only: assert property (@(posedge cfg_serial_clock) disable iff (!rst_n)
        (!cfg_frame_sync && rd_tgl_s2_reg != rd_seen_reg)
        |=> (out_shift_reg == $past(rd_word_reg)))
        else $error("readback word not loaded between frames");

endmodule // ascr_top

// File: shared/ascr_pkg.sv
// Purpose: Shared constants and types for the serial control register bank of the analog front end.
// Assumes: Words are 16 bits, sent most significant bit first, one word per frame.
// Notes:   Field positions are bit indices inside the 16-bit serial word.
package ascr_pkg;

    // Serial word layout.
    localparam int WORD_W     = 16;
    localparam int DATA_W     = 12;
    localparam int CORNER_W   = 11;
    localparam int SEL_W      = 3;
    localparam int CNT_W      = 4;
    localparam int RW_BIT     = 15;
    localparam int SEL_HI     = 14;
    localparam int SEL_LO     = 12;
    localparam logic [CNT_W-1:0] LAST_BIT = 4'hF;

    // General control bank field positions.
    localparam int CTL_TX_ON  = 11;
    localparam int CTL_RX_ON  = 10;
    localparam int CTL_LOOP   = 9;
    localparam int CTL_ADCBUF = 8;
    localparam int CTL_AAF    = 7;
    localparam int CTL_ATTEN  = 6;
    localparam int CTL_DAC    = 5;
    localparam int CTL_TXF    = 4;
    localparam int CTL_DRV    = 3;
    localparam int GAIN_HI    = 2;
    localparam int GAIN_LO    = 0;

    // Filter bank field positions.
    localparam int DUAL_WR_BIT = 11;
    localparam int RANGE_HI   = 10;
    localparam int RANGE_LO   = 8;

    // Receive gain mapping, in dB.
    localparam logic signed [4:0] GAIN_MIN_DB   = -5'sd6;
    localparam logic signed [4:0] GAIN_STEP_DB  = 5'sd3;
    localparam logic [2:0]        GAIN_MAX_CODE = 3'h5;

    // Reset values of the banks.
    localparam logic [DATA_W-1:0]   CTRL_RST   = 12'h000;
    localparam logic [CORNER_W-1:0] CORNER_RST = 11'h000;
    localparam logic [WORD_W-1:0]   WORD_RST   = 16'h0000;

    // Bank select codes.
    typedef enum logic [SEL_W-1:0] {
        BANK_CTRL = 3'b000,
        BANK_TX   = 3'b001,
        BANK_RX   = 3'b010,
        BANK_TEST = 3'b011
    } ascr_bank_e;

    // Decoded settings that drive the analog paths.
    typedef struct packed {
        logic                transmit_power_on_n;
        logic                receive_power_on_n;
        logic                tx_line_hiz;
        logic                loopback;
        logic                adc_buffer_skip;
        logic                rx_antialias_skip;
        logic                tx_atten_6db;
        logic                dac_direct_to_line;
        logic                tx_filter_skip;
        logic                line_driver_skip;
        logic                driver_amp_hiz;
        logic                filter_amp_hiz;
        logic signed [4:0]   rx_gain_db;
        logic [CORNER_W-1:0] tx_corner_word;
        logic [CORNER_W-1:0] rx_corner_word;
        logic [2:0]          tx_range;
        logic [2:0]          rx_range;
    } ascr_afe_ctrl_s;

endpackage

// File: bench/ascr_host_model.sv
// Purpose: Host side of the serial configuration link; shifts words in and captures the readback.
// Assumes: Rising serial edges sample; the serial output is read in the low phase before each rise.
// Notes:   The clock stands still between calls, so any gap a read needs is issued inside xfer.
`timescale 1ns/100ps
module ascr_host_model (
    output logic      cfg_serial_clock,
    output logic      cfg_frame_sync,
    output logic      cfg_serial_in,
    input  wire logic cfg_serial_out
);
    localparam int HALF = 80;

    // Idle levels before the first frame.
    initial begin
        cfg_serial_clock = 1'b0;
        cfg_frame_sync   = 1'b0;
        cfg_serial_in    = 1'b1;
    end

    // Sends the top n bits of w, MSB first, in one frame.
    task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] rd);
        rd = 16'h0000;
        for (int i = 15; i > 15 - n; i--) begin
            cfg_frame_sync = 1'b1;
            cfg_serial_in  = w[i];   // Bit 15 carries the read flag.
            #(HALF);
            rd[i] = cfg_serial_out;
            cfg_serial_clock = 1'b1;
            #(HALF);
            cfg_serial_clock = 1'b0;
        end
        cfg_frame_sync = 1'b0;
        // Six idle clocks give a readback time to load; the released line toggles so no stale bit shows.
        for (int k = 0; k < 6; k++) begin
            cfg_serial_in = ~cfg_serial_in;
            #(HALF);
            cfg_serial_clock = 1'b1;
            #(HALF);
            cfg_serial_clock = 1'b0;
        end
    endtask
endmodule // ascr_host_model

// File: bench/afe_serial_control_regs_tb_top.sv
// Purpose: Self-checking bench for the serial control register bank.
// Assumes: The host model drives the link; clk and reset come from here.
// Notes:   Expected values come from a small bank model kept in this file.
`timescale 1ns/100ps
module afe_serial_control_regs_tb_top;
    import ascr_pkg::*;
    typedef struct packed {logic [15:0] w; logic [4:0] gain;} ascr_row_s;
    logic           clk;
    logic           rst_n;
    logic           sclk;
    logic           fs;
    logic           sdi;
    logic           sdo;
    ascr_afe_ctrl_s afe_ctrl;
    logic [11:0]    m_ctrl;
    logic [10:0]    m_tx;
    logic [10:0]    m_rx;
    logic [15:0]    rd;
    int             mismatches;
    int             comparisons;
    // Words with the gain in dB each should give; the last rows write the corner, test and reserved selects.
    ascr_row_s      rows [14] = '{
        '{16'h0C00, 5'h1A}, '{16'h0C21, 5'h1D}, '{16'h0C12, 5'h00}, '{16'h0C0B, 5'h03},
        '{16'h0E84, 5'h06}, '{16'h0D45, 5'h09}, '{16'h0806, 5'h09}, '{16'h0407, 5'h09},
        '{16'h1123, 5'h09}, '{16'h2456, 5'h09}, '{16'h1FAB, 5'h09}, '{16'h3FFF, 5'h09},
        '{16'h2D55, 5'h09}, '{16'h4ABC, 5'h09}};

    ascr_top uut (.clk(clk), .rst_n(rst_n), .cfg_serial_clock(sclk), .cfg_frame_sync(fs),
                  .cfg_serial_in(sdi), .cfg_serial_out(sdo), .afe_ctrl(afe_ctrl));
    ascr_host_model host (.cfg_serial_clock(sclk), .cfg_frame_sync(fs), .cfg_serial_in(sdi),
                          .cfg_serial_out(sdo));

    // System clock, 50 ns period.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Decode of the bank model into the expected control outputs.
    function automatic ascr_afe_ctrl_s exp_ctrl();
        ascr_afe_ctrl_s e;
        int g;
        e = '0;
        g = (m_ctrl[2:0] > 3'h5) ? 5 : int'(m_ctrl[2:0]);
        e.transmit_power_on_n = m_ctrl[11];
        e.tx_line_hiz = ~m_ctrl[11];
        e.receive_power_on_n = m_ctrl[10];
        e.loopback = m_ctrl[9];
        e.adc_buffer_skip = m_ctrl[8];
        e.rx_antialias_skip = m_ctrl[7];
        e.tx_atten_6db = m_ctrl[6];
        e.dac_direct_to_line = m_ctrl[5];
        e.tx_filter_skip = m_ctrl[4];
        e.line_driver_skip = m_ctrl[3];
        e.driver_amp_hiz = m_ctrl[5] | m_ctrl[3];
        e.filter_amp_hiz = m_ctrl[4];
        e.rx_gain_db = 5'(g * 3 - 6);
        e.tx_corner_word = m_tx;
        e.tx_range = m_tx[10:8];
        e.rx_corner_word = m_rx;
        e.rx_range = m_rx[10:8];
        return e;
    endfunction

    task automatic cmp_ctrl(input string what, input ascr_afe_ctrl_s exp);
        comparisons++;
        if (afe_ctrl !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, afe_ctrl);
        end
    endtask

    task automatic cmp_word(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One full word, then the bank model follows it; reserved selects change nothing.
    task automatic send(input logic [15:0] w);
        host.xfer(w, 16, rd);
        if (!w[15]) begin
            case (w[14:12])
                3'h0: m_ctrl = w[11:0];
                3'h1: begin
                    m_tx = w[10:0];
                    if (w[11]) m_rx = w[10:0];
                end
                3'h2: begin
                    m_rx = w[10:0];
                    if (w[11]) m_tx = w[10:0];
                end
                default: ;
            endcase
        end
        @(negedge clk);
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Watchdog: the tests need about 90 us of serial traffic.
    initial begin
        #500000;
        mismatches++;
        final_report();
    end

    initial begin
        rst_n = 1'b0;
        mismatches = 0;
        comparisons = 0;
        m_ctrl = '0;
        m_tx = '0;
        m_rx = '0;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        cmp_ctrl("reset decode", exp_ctrl());
        $display("test reset done");
        foreach (rows[i]) begin
            send(rows[i].w);
            cmp_ctrl("bank decode", exp_ctrl());
            cmp_word("gain", {11'h000, rows[i].gain}, {11'h000, afe_ctrl.rx_gain_db});
        end
        $display("test table done");
        // Read each bank twice; the second frame shifts out the first answer.
        for (int s = 0; s < 4; s++) begin
            send({1'b1, 3'(s), 12'h000});
            send({1'b1, 3'(s), 12'h000});
            cmp_word("readback", {1'b1, 3'(s), (s == 0) ? m_ctrl : (s == 1) ? {1'b0, m_tx} :
                     (s == 2) ? {1'b0, m_rx} : 12'h000}, rd);
        end
        $display("test readback done");
        // A short frame must be dropped whole, and the next full one taken.
        host.xfer(16'h0FFF, 8, rd);
        repeat (4) @(negedge clk);
        cmp_ctrl("partial frame", exp_ctrl());
        send(16'h0C3A);
        cmp_ctrl("after partial", exp_ctrl());
        $display("test partial done");
        // Reset in mid-run clears every bank.
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        cmp_ctrl("in reset", '0);
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        m_ctrl = '0;
        m_tx = '0;
        m_rx = '0;
        repeat (2) @(negedge clk);
        cmp_ctrl("after reset", exp_ctrl());
        send(16'h9000);
        send(16'h9000);
        cmp_word("tx after reset", 16'h9000, rd);
        $display("test mid reset done");
        final_report();
    end
endmodule // afe_serial_control_regs_tb_top
